// File: common/frwc_link_if.sv
interface frwc_link_if;
    logic       csN;
    logic       linkClk;
    logic [7:0] dq;
    modport host (output csN, output linkClk, output dq);
    modport device (input csN, input linkClk, input dq);
endinterface

// File: common/frwc_pkg.sv
// How it works
// - single bit, octal SDR or octal DDR framing
// - set write enable command sets enable flag
// - modifying commands run only while enabled
// - clear write enable command clears enable flag
// - clear write enable ignored while busy
// - clear fail flags zeroes both error flags
// - clear fail flags works busy, keeps enable
// - clear ecc zeroes ecc flags, trap, counter; an ecc event in the same cycle keeps old flags
// - clear ecc needs no enable, keeps it
// - host sends address then one data byte, sent twice in octal DDR
// - write any register needs enable first
// - busy and error flags report register write
// - read only bits never change, no error
// - otp bits only leave default, silently
// - nonvolatile change takes erase plus program time
// - failed update sets error and busy
// - stays busy until clear fail flags
// - write any never touches lock register
// - write any never touches integrity register
// - lock command clears lock, blocks ppb changes
// - locked read password mode confines reads
// - lock command needs enable, busy ends
package frwc_pkg;
    localparam int CLK_MHZ = 200;
    typedef enum logic [1:0] {MODE_SINGLE, MODE_OCTAL_SDR, MODE_OCTAL_DDR} frwc_mode_type;
    typedef enum logic [2:0] {
        CMD_SET_WE, CMD_CLR_WE, CMD_CLR_FAIL, CMD_CLR_ECC, CMD_WRITE_ANY, CMD_LOCK
    } frwc_cmd_type;
    typedef enum logic [1:0] {ST_IDLE, ST_NV_WRITE, ST_LOCK_WRITE, ST_FAILED} frwc_state_type;
    localparam logic [7:0] OP_SET_WE    = 8'h06;
    localparam logic [7:0] OP_CLR_WE    = 8'h04;
    localparam logic [7:0] OP_CLR_FAIL  = 8'h82;
    localparam logic [7:0] OP_CLR_ECC   = 8'h1b;
    localparam logic [7:0] OP_WRITE_ANY = 8'h71;
    localparam logic [7:0] OP_LOCK      = 8'ha6;
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_WE_BIT   = 1;
    localparam int ST_ERS_BIT  = 5;
    localparam int ST_PRG_BIT  = 6;
    localparam logic [3:0]  ADDR_BYTES   = 4'h4;
    localparam int          REG_COUNT    = 4;
    localparam logic [31:0] REG_ADDR_LOCK      = 32'h0000_0010;
    localparam logic [31:0] REG_ADDR_INTEGRITY = 32'h0000_0020;
    localparam logic [3:0]  REG_NV_MASK  = 4'hc;
    localparam logic [31:0] REG_RO_MASK  = 32'h0300_8000;
    localparam logic [31:0] REG_OTP_MASK = 32'h1000_0100;
    localparam logic [31:0] REG_OTP_DEF  = 32'h0000_0000;
    localparam logic [31:0] REG_RESET    = 32'h0300_0000;
    localparam logic        LOCK_RESET   = 1'b1;
    localparam int T_NV_WRITE_NS   = 2000;
    localparam int NV_WRITE_CYCLES = (T_NV_WRITE_NS * CLK_MHZ + 999) / 1000;
    localparam int T_LOCK_NS       = 500;
    localparam int LOCK_CYCLES     = (T_LOCK_NS * CLK_MHZ + 999) / 1000;
    localparam int LINK_PERIOD_NS  = 80;
    localparam int LINK_PERIOD_CYCLES = LINK_PERIOD_NS * CLK_MHZ / 1000;
    localparam logic [3:0] PH_LAST    = 4'(LINK_PERIOD_CYCLES - 1);
    localparam logic [3:0] PH_RISE    = 4'(LINK_PERIOD_CYCLES / 2);
    localparam logic [3:0] PH_Q1      = 4'(LINK_PERIOD_CYCLES / 4);
    localparam logic [3:0] PH_Q3      = 4'(3 * LINK_PERIOD_CYCLES / 4);
    localparam logic [3:0] H_CMD_OFF    = 4'h0;
    localparam logic [3:0] H_ADDR_OFF   = 4'h4;
    localparam logic [3:0] H_DATA_OFF   = 4'h8;
    localparam logic [3:0] H_STATUS_OFF = 4'hc;

    function automatic logic [7:0] frwc_opcode(input logic [2:0] k);
        case (k)
            3'h0:    return OP_SET_WE;
            3'h1:    return OP_CLR_WE;
            3'h2:    return OP_CLR_FAIL;
            3'h3:    return OP_CLR_ECC;
            3'h4:    return OP_WRITE_ANY;
            3'h5:    return OP_LOCK;
            default: return 8'h00;
        endcase
    endfunction

    function automatic logic [7:0] frwc_byte(input logic [31:0] m, input logic [1:0] i);
        return m[{i, 3'b000} +: 8];
    endfunction
endpackage

// File: rtl/frwc_device.sv
// Local design decisions: the AXI4-Lite register port and the register offsets.
module frwc_device
    import frwc_pkg::*;
#(
    parameter int NV_CYCLES   = NV_WRITE_CYCLES,
    parameter int LOCK_CYC    = LOCK_CYCLES,
    parameter int SECTOR_BITS = 18
) (
    input  wire logic          clock,
    input  wire logic          rst_n,
    frwc_link_if.device        link,
    input  wire frwc_mode_type linkMode,
    input  wire logic          injectEraseFail,
    input  wire logic          injectProgramFail,
    input  wire logic          eccEvent,
    input  wire logic          eccTwoBit,
    input  wire logic [31:0]   eccAddr,
    input  wire logic          readPwdMode,
    input  wire logic          pwdSupplied,
    input  wire logic [31:0]   readAddrIn,
    input  wire logic          ppbReq,
    output logic               ppbAbort,
    output logic [31:0]        readAddrOut,
    output logic [7:0]         statusRegOne,
    output logic               protectLockBit,
    output logic [7:0]         eccStatusReg,
    output logic [1:0]         interruptStatusReg,
    output logic [31:0]        eccAddressTrapReg,
    output logic [15:0]        eccDetectCounterReg,
    output logic [31:0]        regFile
);
    logic           rxValid, frameStart, frameEnd;
    logic [7:0]     rxByte;
    logic [3:0]     cnt_q;
    logic [7:0]     op_q, opCheck_q, data_q, pend_q;
    logic [31:0]    addr_q;
    logic [1:0]     pendIdx_q;
    frwc_state_type state_q;
    logic [15:0]    timer_q;
    logic           writeEnableFlag_q, programErr_q, eraseErr_q, lock_q;
    logic           eccTwo_q, eccOne_q;

    frwc_link_rx frwc_link_rx_i (
        .clock      (clock),
        .rst_n      (rst_n),
        .csN        (link.csN),
        .linkClk    (link.linkClk),
        .dq         (link.dq),
        .mode       (linkMode),
        .byteValid  (rxValid),
        .byteData   (rxByte),
        .frameStart (frameStart),
        .frameEnd   (frameEnd)
    );

    wire       octal  = linkMode != MODE_SINGLE;
    wire [3:0] hdrLen = octal ? 4'h2 : 4'h1;
    wire [3:0] argIdx = cnt_q - hdrLen;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q     <= 4'h0;
            op_q      <= 8'h00;
            opCheck_q <= 8'h00;
            addr_q    <= 32'h0;
            data_q    <= 8'h00;
        end else if (frameStart) begin
            cnt_q <= 4'h0;
        end else if (rxValid) begin
            if (cnt_q != 4'hf) cnt_q <= cnt_q + 4'h1;
            if (cnt_q == 4'h0) op_q <= rxByte;
            if (cnt_q == 4'h1) opCheck_q <= rxByte;
            if (cnt_q >= hdrLen && argIdx < ADDR_BYTES) addr_q <= {addr_q[23:0], rxByte};
            if (cnt_q >= hdrLen && argIdx == ADDR_BYTES) data_q <= rxByte;
        end
    end

    // command decode at the end of the frame
    wire go          = frameEnd && cnt_q >= hdrLen && (!octal || opCheck_q == ~op_q);
    wire busy        = state_q != ST_IDLE;
    wire isSetWe     = go && op_q == OP_SET_WE;
    wire isClrWe     = go && op_q == OP_CLR_WE;
    wire isClrFail   = go && op_q == OP_CLR_FAIL;
    wire isClrEcc    = go && op_q == OP_CLR_ECC;
    wire argsOk      = cnt_q > hdrLen + ADDR_BYTES;
    wire doWriteAny  = go && op_q == OP_WRITE_ANY && argsOk && writeEnableFlag_q && !busy;
    wire doLock      = go && op_q == OP_LOCK && writeEnableFlag_q && !busy;

    // register merge for write any
    wire [1:0] regIdx = addr_q[1:0];
    wire       mapped = addr_q < REG_COUNT && addr_q != REG_ADDR_LOCK
                        && addr_q != REG_ADDR_INTEGRITY;
    wire [7:0] oldVal = regFile[{regIdx, 3'b000} +: 8];
    wire [7:0] roM    = frwc_byte(REG_RO_MASK, regIdx);
    wire [7:0] otpM   = frwc_byte(REG_OTP_MASK, regIdx);
    wire [7:0] otpDef = frwc_byte(REG_OTP_DEF, regIdx);
    wire [7:0] otpNew = (~(data_q ^ otpDef) & oldVal) | ((data_q ^ otpDef) & ~otpDef);
    wire [7:0] newVal = (oldVal & roM) | (data_q & ~roM & ~otpM) | (otpNew & otpM);
    wire       needNv = REG_NV_MASK[regIdx] && newVal != oldVal;
    wire       startNv   = doWriteAny && mapped && needNv;
    wire       timerDone = timer_q == 16'h0;
    wire       nvDone    = state_q == ST_NV_WRITE && timerDone;
    wire       lockDone  = state_q == ST_LOCK_WRITE && timerDone;
    wire       failAny   = injectEraseFail | injectProgramFail;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            timer_q <= 16'h0;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (startNv) begin
                        state_q <= ST_NV_WRITE;
                        timer_q <= 16'(NV_CYCLES - 1);
                    end else if (doLock) begin
                        state_q <= ST_LOCK_WRITE;
                        timer_q <= 16'(LOCK_CYC - 1);
                    end
                end
                ST_NV_WRITE: begin
                    if (timerDone) state_q <= failAny ? ST_FAILED : ST_IDLE;
                    else timer_q <= timer_q - 16'h1;
                end
                ST_LOCK_WRITE: begin
                    if (timerDone) state_q <= ST_IDLE;
                    else timer_q <= timer_q - 16'h1;
                end
                ST_FAILED: begin
                    if (isClrFail) state_q <= ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            regFile   <= REG_RESET;
            pend_q    <= 8'h00;
            pendIdx_q <= 2'h0;
        end else begin
            if (doWriteAny && mapped && !needNv) regFile[{regIdx, 3'b000} +: 8] <= newVal;
            if (startNv) begin
                pend_q    <= newVal;
                pendIdx_q <= regIdx;
            end
            if (nvDone && !failAny) regFile[{pendIdx_q, 3'b000} +: 8] <= pend_q;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            writeEnableFlag_q <= 1'b0;
        end else begin
            if (nvDone || lockDone || (doWriteAny && !startNv)) writeEnableFlag_q <= 1'b0;
            if (isClrWe && !busy) writeEnableFlag_q <= 1'b0;
            if (isSetWe) writeEnableFlag_q <= 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            eraseErr_q   <= 1'b0;
            programErr_q <= 1'b0;
            lock_q       <= LOCK_RESET;
        end else begin
            if (isClrFail) begin
                eraseErr_q   <= 1'b0;
                programErr_q <= 1'b0;
            end
            if (nvDone && injectEraseFail) eraseErr_q <= 1'b1;
            if (nvDone && !injectEraseFail && injectProgramFail) programErr_q <= 1'b1;
            if (lockDone) lock_q <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            eccTwo_q            <= 1'b0;
            eccOne_q            <= 1'b0;
            interruptStatusReg  <= 2'h0;
            eccAddressTrapReg   <= 32'h0;
            eccDetectCounterReg <= 16'h0;
        end else begin
            if (isClrEcc) begin
                eccTwo_q            <= 1'b0;
                eccOne_q            <= 1'b0;
                interruptStatusReg  <= 2'h0;
                eccAddressTrapReg   <= 32'h0;
                eccDetectCounterReg <= 16'h0;
            end
            if (eccEvent) begin
                eccTwo_q              <= eccTwo_q | eccTwoBit;
                eccOne_q              <= eccOne_q | ~eccTwoBit;
                interruptStatusReg[1] <= interruptStatusReg[1] | eccTwoBit;
                interruptStatusReg[0] <= interruptStatusReg[0] | ~eccTwoBit;
                eccAddressTrapReg     <= eccAddr;
                if (eccDetectCounterReg != 16'hffff || isClrEcc)
                    eccDetectCounterReg <= (isClrEcc ? 16'h0 : eccDetectCounterReg) + 16'h1;
            end
        end
    end

    wire confine = readPwdMode && lock_q && !pwdSupplied;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) readAddrOut <= 32'h0;
        else readAddrOut <= confine ? {{(32 - SECTOR_BITS){1'b0}}, readAddrIn[SECTOR_BITS-1:0]}
                                    : readAddrIn;
    end

    assign ppbAbort       = ppbReq & ~lock_q;
    assign protectLockBit = lock_q;
    assign eccStatusReg   = {3'b000, eccTwo_q, eccOne_q, 3'b000};
    always_comb begin
        statusRegOne              = 8'h00;
        statusRegOne[ST_BUSY_BIT] = busy;
        statusRegOne[ST_WE_BIT]   = writeEnableFlag_q;
        statusRegOne[ST_ERS_BIT]  = eraseErr_q;
        statusRegOne[ST_PRG_BIT]  = programErr_q;
    end
endmodule

// File: rtl/frwc_host.sv
module frwc_host
    import frwc_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst_n,
    frwc_link_if.host        link,
    input  wire logic [31:0] awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [31:0] araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready
);
    logic          awHeld_q, wHeld_q, active_q, first_q, csN_q, clk_q;
    logic [31:0]   awAddr_q, wData_q, addrReg_q, cmdReg_q;
    logic [3:0]    wStrb_q, phase_q;
    logic [7:0]    dataReg_q, dq_q;
    logic [63:0]   sh_q;
    logic [6:0]    left_q;
    frwc_mode_type mode_q;

    assign awready = ~awHeld_q;
    assign wready  = ~wHeld_q;
    assign arready = ~rvalid;
    assign link.csN     = csN_q;
    assign link.linkClk = clk_q;
    assign link.dq      = dq_q;

    wire        doWrite = awHeld_q & wHeld_q & ~bvalid;
    wire [31:0] wMask   = {{8{wStrb_q[3]}}, {8{wStrb_q[2]}}, {8{wStrb_q[1]}}, {8{wStrb_q[0]}}};
    wire        wMapped = awAddr_q[31:4] == 28'h0 && awAddr_q[1:0] == 2'h0;
    wire [3:0]  wOff    = awAddr_q[3:0];
    wire [7:0]  op      = frwc_opcode(wData_q[2:0]);
    wire        single  = wData_q[5:4] == 2'h0;
    wire        isWA    = wData_q[2:0] == 3'h4;
    wire        legal   = wData_q[2:0] <= 3'h5 && wData_q[5:4] != 2'h3;
    wire        start   = doWrite && wMapped && wOff == H_CMD_OFF && wStrb_q[0] && legal && !active_q;
    wire [6:0]  nb      = isWA ? (single ? 7'h6 : (wData_q[5:4] == 2'h1 ? 7'h7 : 7'h8))
                               : (single ? 7'h1 : 7'h2);
    wire [63:0] frame   = single ? {op, addrReg_q, dataReg_q, 16'h0}
                                 : {op, ~op, addrReg_q, dataReg_q, dataReg_q};
    wire        modeSingle = mode_q == MODE_SINGLE;
    wire        change  = active_q && (phase_q == PH_Q1 || (mode_q == MODE_OCTAL_DDR && phase_q == PH_Q3));
    wire [63:0] shNext  = modeSingle ? {sh_q[62:0], 1'b0} : {sh_q[55:0], 8'h00};
    wire [7:0]  dqFirst = modeSingle ? {7'h0, sh_q[63]} : sh_q[63:56];
    wire [7:0]  dqNext  = modeSingle ? {7'h0, shNext[63]} : shNext[63:56];
    wire        rMapped = araddr[31:4] == 28'h0 && araddr[1:0] == 2'h0;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            {awHeld_q, wHeld_q, bvalid} <= 3'h0;
            awAddr_q <= 32'h0;
            wData_q  <= 32'h0;
            wStrb_q  <= 4'h0;
            bresp    <= 2'h0;
        end else begin
            if (awvalid && awready) {awHeld_q, awAddr_q} <= {1'b1, awaddr};
            if (wvalid && wready) {wHeld_q, wData_q, wStrb_q} <= {1'b1, wdata, wstrb};
            if (doWrite) begin
                {awHeld_q, wHeld_q, bvalid} <= 3'h1;
                bresp <= wMapped ? 2'h0 : 2'h2;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            addrReg_q <= 32'h0;
            dataReg_q <= 8'h00;
            cmdReg_q  <= 32'h0;
        end else if (doWrite && wMapped) begin
            if (wOff == H_ADDR_OFF) addrReg_q <= (addrReg_q & ~wMask) | (wData_q & wMask);
            if (wOff == H_DATA_OFF && wStrb_q[0]) dataReg_q <= wData_q[7:0];
            if (start) cmdReg_q <= {26'h0, wData_q[5:0]};
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            {rvalid, rdata, rresp} <= 35'h0;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rresp  <= rMapped && araddr[3:0] != 4'h0 || rMapped ? 2'h0 : 2'h2;
            unique case (araddr[3:0])
                H_CMD_OFF:    rdata <= cmdReg_q;
                H_ADDR_OFF:   rdata <= addrReg_q;
                H_DATA_OFF:   rdata <= {24'h0, dataReg_q};
                H_STATUS_OFF: rdata <= {31'h0, active_q};
                default:      rdata <= 32'h0;
            endcase
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
        end
    end

    // link engine, clock rises mid period, data moves at the first quarter, and at the third too in octal DDR
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            {active_q, first_q, clk_q} <= 3'h0;
            csN_q   <= 1'b1;
            phase_q <= 4'h0;
            sh_q    <= 64'h0;
            left_q  <= 7'h0;
            dq_q    <= 8'h00;
            mode_q  <= MODE_SINGLE;
        end else if (start) begin
            {active_q, first_q, csN_q} <= 3'h6;
            phase_q <= 4'h0;
            sh_q    <= frame;
            left_q  <= single ? 7'(nb * 7'h8) : nb;
            mode_q  <= frwc_mode_type'(wData_q[5:4]);
        end else if (active_q) begin
            phase_q <= phase_q == PH_LAST ? 4'h0 : phase_q + 4'h1;
            if (phase_q == PH_RISE - 4'h1) clk_q <= 1'b1;
            if (phase_q == PH_LAST) clk_q <= 1'b0;
            if (change && first_q) begin
                first_q <= 1'b0;
                dq_q    <= dqFirst;
            end else if (change && left_q == 7'h1) begin
                {active_q, clk_q, csN_q} <= 3'h1;
            end else if (change) begin
                sh_q   <= shNext;
                dq_q   <= dqNext;
                left_q <= left_q - 7'h1;
            end
        end
    end
endmodule

// File: rtl/frwc_link_rx.sv
module frwc_link_rx
    import frwc_pkg::*;
(
    input  wire logic          clock,
    input  wire logic          rst_n,
    input  wire logic          csN,
    input  wire logic          linkClk,
    input  wire logic [7:0]    dq,
    input  wire frwc_mode_type mode,
    output logic               byteValid,
    output logic [7:0]         byteData,
    output logic               frameStart,
    output logic               frameEnd
);
    logic       cs1_q, cs2_q, cs3_q, ck1_q, ck2_q, ck3_q;
    logic [7:0] dq1_q, dq2_q, sh_q;
    logic [2:0] bit_q;

    wire rise   = ck2_q & ~ck3_q;
    wire fall   = ~ck2_q & ck3_q;
    wire sample = ~cs2_q & (rise | (mode == MODE_OCTAL_DDR & fall));
    wire single = mode == MODE_SINGLE;
    wire [7:0] shNext = {sh_q[6:0], dq2_q[0]};
    assign frameStart = cs3_q & ~cs2_q;
    assign frameEnd   = ~cs3_q & cs2_q;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            {cs1_q, cs2_q, cs3_q} <= 3'h7;
            {ck1_q, ck2_q, ck3_q} <= 3'h0;
            dq1_q <= 8'h00;
            dq2_q <= 8'h00;
        end else begin
            {cs1_q, cs2_q, cs3_q} <= {csN, cs1_q, cs2_q};
            {ck1_q, ck2_q, ck3_q} <= {linkClk, ck1_q, ck2_q};
            dq1_q <= dq;
            dq2_q <= dq1_q;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sh_q      <= 8'h00;
            bit_q     <= 3'h0;
            byteValid <= 1'b0;
            byteData  <= 8'h00;
        end else begin
            byteValid <= 1'b0;
            if (frameStart) begin
                bit_q <= 3'h0;
            end else if (sample && single) begin
                sh_q  <= shNext;
                bit_q <= bit_q + 3'h1;
                if (bit_q == 3'h7) begin
                    byteValid <= 1'b1;
                    byteData  <= shNext;
                end
            end else if (sample) begin
                byteValid <= 1'b1;
                byteData  <= dq2_q;
            end
        end
    end
endmodule

// File: testbench/flash_register_write_cmds_tb.sv
module flash_register_write_cmds_tb import frwc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int NVC = 20;
    localparam int LKC = 10;
    logic clock = 1'b0, rst_n = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid, arready, rvalid;
    logic injectEraseFail = 1'b0, injectProgramFail = 1'b0, eccEvent = 1'b0, eccTwoBit = 1'b0;
    logic readPwdMode = 1'b1, pwdSupplied = 1'b0, ppbReq = 1'b1, ppbAbort, protectLockBit;
    logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata, rng = 32'h4d;
    logic [31:0] eccAddr = 32'h0, readAddrIn = 32'h0, readAddrOut, eccAddressTrapReg;
    logic [31:0] regFile, expect_q = REG_RESET;
    logic [7:0]  statusRegOne, eccStatusReg, d;
    logic [15:0] eccDetectCounterReg;
    logic [3:0]  wstrb = 4'hf;
    logic [1:0]  bresp, rresp, interruptStatusReg, resp;
    frwc_mode_type linkMode = MODE_SINGLE;
    int mismatches = 0, samplesChecked = 0, i;
    frwc_link_if link();
    frwc_host frwc_host_i (.*);
    frwc_device #(.NV_CYCLES(NVC), .LOCK_CYC(LKC)) frwc_device_i (.*);
    frwc_props frwc_props_i (.clock(clock), .rst_n(rst_n), .csN(link.csN),
        .linkClk(link.linkClk), .dq(link.dq));
    function automatic logic [31:0] xs(input logic [31:0] v);
        v = v ^ (v << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction
    function automatic logic [7:0] expReg(input logic [7:0] o, input logic [7:0] v, input int k);
        logic [7:0] ro, ot;
        ro = REG_RO_MASK[8*k+:8];
        ot = REG_OTP_MASK[8*k+:8];
        return (o & ro) | ((o | v) & ot) | (v & ~ro & ~ot);
    endfunction
    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", samplesChecked, mismatches);
        if (mismatches == 0 && samplesChecked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic axiWr(input logic [31:0] a, input logic [31:0] v, output logic [1:0] r);
        awaddr  <= a;
        wdata   <= v;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge clock);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        r = bresp;
        @(posedge clock);
    endtask
    task automatic axiRd(input logic [31:0] a, output logic [31:0] v);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge clock);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        v = rdata;
        @(posedge clock);
    endtask
    task automatic cmd(input int k);
        logic [31:0] s;
        axiWr(32'(H_CMD_OFF), {26'h0, linkMode, 1'b0, 3'(k)}, resp);
        do axiRd(32'(H_STATUS_OFF), s); while (s[0]);
        repeat (6) @(posedge clock);
    endtask
    task automatic wany(input logic [31:0] a, input logic [7:0] v);
        axiWr(32'(H_ADDR_OFF), a, resp);
        axiWr(32'(H_DATA_OFF), {24'h0, v}, resp);
        cmd(4);
    endtask
    task automatic addrChk(input logic [31:0] exp);
        readAddrIn <= ~rng;
        repeat (2) @(posedge clock);
        chk("read address", readAddrOut, exp);
    endtask
    initial forever #2.5 clock = ~clock;
    initial begin
        repeat (90000) @(posedge clock);
        mismatches++;
        end_of_test();
    end
    initial begin
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        repeat (4) @(posedge clock);
        addrChk({14'h0, ~rng[17:0]});
        for (int m = 0; m < 3; m++) begin
            linkMode <= frwc_mode_type'(m);
            rng = xs(rng);
            i = int'(rng[1:0]);
            d = rng[15:8];
            @(posedge clock);
            cmd(0);
            chk("status", 32'(statusRegOne), 32'h02);
            cmd(1);
            chk("status", 32'(statusRegOne), 32'h00);
            wany(32'(i), d);
            chk("registers", regFile, expect_q);
            cmd(0);
            wany(32'(i), d);
            d = expReg(expect_q[8*i+:8], d, i);
            chk("busy", 32'(statusRegOne[0]), 32'(i > 1 && d != expect_q[8*i+:8]));
            expect_q[8*i+:8] = d;
            repeat (NVC + 4) @(posedge clock);
            chk("registers", regFile, expect_q);
            chk("status", 32'(statusRegOne), 32'h00);
            {injectEraseFail, injectProgramFail} <= {m != 1, 1'b1};
            cmd(0);
            wany(32'h2, ~regFile[23:16]);
            repeat (NVC + 4) @(posedge clock);
            chk("status", 32'(statusRegOne), m == 1 ? 32'h41 : 32'h21);
            chk("registers", regFile, expect_q);
            {injectEraseFail, injectProgramFail} <= 2'h0;
            cmd(0);
            cmd(1);
            chk("status", 32'(statusRegOne), m == 1 ? 32'h43 : 32'h23);
            cmd(2);
            chk("status", 32'(statusRegOne), 32'h02);
            cmd(1);
            {eccTwoBit, eccAddr} <= {rng[16], rng};
            eccEvent  <= 1'b1;
            @(posedge clock);
            eccEvent <= 1'b0;
            cmd(3);
            chk("ecc", {eccStatusReg, 6'h0, interruptStatusReg, eccDetectCounterReg}, 0);
            chk("trap", eccAddressTrapReg, 32'h0);
            chk("status", 32'(statusRegOne), 32'h00);
        end
        axiWr(32'h40, 32'h0, resp);
        chk("response", 32'(resp), 32'h2);
        cmd(0);
        wany(REG_ADDR_LOCK, 8'h00);
        chk("lock", 32'(protectLockBit), 32'h1);
        cmd(5);
        chk("lock", 32'(protectLockBit), 32'h1);
        cmd(0);
        cmd(5);
        chk("status", 32'(statusRegOne), 32'h03);
        repeat (LKC + 4) @(posedge clock);
        chk("status", 32'(statusRegOne), 32'h00);
        chk("lock", {30'h0, protectLockBit, ppbAbort}, 32'h1);
        addrChk(~rng);
        end_of_test();
    end
endmodule

// File: testbench/frwc_props.sv
module frwc_props (
    input wire logic       clock,
    input wire logic       rst_n,
    input wire logic       csN,
    input wire logic       linkClk,
    input wire logic [7:0] dq
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       linkClk_q;
    logic [5:0] riseCount_q;
    wire  logic linkRise = linkClk & ~linkClk_q;
    wire  logic [5:0] riseCount_d = csN ? 6'h00 : riseCount_q + {5'h00, linkRise};
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            linkClk_q   <= 1'b0;
            riseCount_q <= 6'h00;
        end else begin
            linkClk_q   <= linkClk;
            riseCount_q <= riseCount_d;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    sequence s_high; linkClk [*8] ##1 !linkClk; endsequence
    sequence s_firstRise; !linkClk ##[1:16] $rose(linkClk); endsequence
    property p_idleStill; csN |-> !linkClk; endproperty
    property p_highLen; $rose(linkClk) |-> s_high; endproperty
    property p_lowLen; $fell(linkClk) |-> !linkClk [*8]; endproperty
    property p_dqRise; $rose(linkClk) |-> $stable(dq); endproperty
    property p_dqFall; $fell(linkClk) |-> $stable(dq); endproperty
    property p_dqHold; $changed(dq) && !csN |=> $stable(dq) [*7]; endproperty
    property p_start; $fell(csN) |-> s_firstRise; endproperty
    property p_units; $rose(csN) |-> riseCount_q inside {1, 2, 4, 7, 8, 48}; endproperty
    a_idleStill: assert property (p_idleStill) else $error("idle clock");
    a_highLen: assert property (p_highLen) else $error("high phase");
    a_lowLen: assert property (p_lowLen) else $error("low phase");
    a_dqRise: assert property (p_dqRise) else $error("data at rise");
    a_dqFall: assert property (p_dqFall) else $error("data at fall");
    a_dqHold: assert property (p_dqHold) else $error("data hold");
    a_start: assert property (p_start) else $error("frame start");
    a_units: assert property (p_units) else $error("unit count");
endmodule
